// ---- src/agu_defines.svh ----
// Constants for the data space address generator
`ifndef AGU_DEFINES_SVH
`define AGU_DEFINES_SVH
`define PC_W          23
`define INSN_W        24
`define WREG_N        16
`define WREG_W        16
`define SP_IDX        4'hf
`define PAGE_W        10
`define PAGE_RST      10'h001
`define PAGE_EDS_MIN  10'h001
`define PAGE_EDS_MAX  10'h1ff
`define PAGE_PSV_MIN  10'h200
`define PAGE_PSV_MAX  10'h2ff
`define EA_TOP        15
`define EXT_W         24
`define PSV_W         8
`define MOD_END_RST   16'h0001
`endif

// ---- src/agu_pkg.sv ----
// Types for the address generator
package agu_pkg;
	typedef enum logic [2:0]
	{
		AM_PRE_INC  = 3'h0,
		AM_PRE_DEC  = 3'h1,
		AM_POST_INC = 3'h2,
		AM_POST_DEC = 3'h3,
		AM_OFFSET   = 3'h4,
		AM_DIRECT   = 3'h5,
		AM_PLAIN    = 3'h6
	} ea_mode_t;
	typedef enum logic [3:0]
	{
		ST_IDLE   = 4'h1,
		ST_ADDR   = 4'h2,
		ST_SECOND = 4'h4,
		ST_REPEAT = 4'h8
	} seq_state_t;
endpackage : agu_pkg

// ---- src/addr_calc.sv ----
// One address generator: pointer modification, modulo and bit-reverse
`timescale 1ns/100ps
`include "agu_defines.svh"
module addr_calc
#(
	parameter bit HAS_DSP = 1'b1
)
(
	input  wire logic [15:0]     base,
	input  wire logic [15:0]     offset,
	input  wire agu_pkg::ea_mode_t mode,
	input  wire logic            modEn,
	input  wire logic [15:0]     modStart,
	input  wire logic [15:0]     modEnd,
	input  wire logic            brevEn,
	input  wire logic [14:0]     brevMod,
	output logic      [15:0]     ea,
	output logic      [15:0]     newPtr,
	output logic                 pageOver,
	output logic                 pageUnder,
	output logic                 wrapMode
);
	// ----------------------------------------
	// Bit-reversed carry add
	// ----------------------------------------
	function automatic logic [15:0] brevAdd(input logic [15:0] a, input logic [14:0] m);
		logic [15:0] ra;
		logic [15:0] rm;
		logic [15:0] s;
		ra = {<<{a}};
		rm = {<<{m, 1'b0}};
		s  = ra + rm;
		return {<<{s}};
	endfunction : brevAdd

	wire logic        isInc   = (mode == agu_pkg::AM_PRE_INC) || (mode == agu_pkg::AM_POST_INC);
	wire logic        isDec   = (mode == agu_pkg::AM_PRE_DEC) || (mode == agu_pkg::AM_POST_DEC);
	wire logic        isPre   = (mode == agu_pkg::AM_PRE_INC) || (mode == agu_pkg::AM_PRE_DEC);
	wire logic        isOff   = (mode == agu_pkg::AM_OFFSET);
	wire logic [16:0] incSum  = {1'b0, base} + 17'h00002;
	wire logic [16:0] decSum  = {1'b0, base} - 17'h00002;
	wire logic [15:0] offSum  = base + offset;
	// reduced core has no modulo or bit-reverse
	wire logic        useBrev = HAS_DSP && brevEn && (mode == agu_pkg::AM_POST_INC);
	wire logic        useMod  = HAS_DSP && modEn && !useBrev && (isInc || isDec);
	wire logic [15:0] stepped = isInc ? incSum[15:0] : decSum[15:0];
	wire logic [15:0] modNext = (isInc && base == (modEnd & 16'hfffe)) ? modStart :
		(isDec && base == modStart) ? (modEnd & 16'hfffe) : stepped;
	wire logic [15:0] brNext  = brevAdd(base, brevMod);
	wire logic        topIn   = base[`EA_TOP];
	wire logic [15:0] rawNext = useBrev ? brNext : useMod ? modNext : stepped;

	// wrapping modes leaving the upper window
	wire logic        wrapOut = topIn && (isOff ? !offSum[15] : (useMod || useBrev) && !rawNext[15]);
	wire logic [15:0] eaRaw   = isOff ? offSum : (isPre ? rawNext : base);

	assign newPtr    = (isInc || isDec) ? rawNext : base;
	// even word address, top bit kept inside the window
	assign ea        = (eaRaw | {pageOver || pageUnder, 15'h0000}) & 16'hfffe;
	assign wrapMode  = isOff || useMod || useBrev;
	assign pageOver  = (topIn && isInc && !useMod && !useBrev && incSum[16]) || wrapOut;
	assign pageUnder = topIn && isDec && !useMod && (decSum[15] == 1'b0);
endmodule : addr_calc

// ---- src/cpu_data_space_addressing.sv ----
// Core address generation and execution framework
`timescale 1ns/100ps
`include "agu_defines.svh"
module cpu_data_space_addressing
#(
	parameter bit HAS_DSP = 1'b1
)
(
	input  wire logic                 clock,
	input  wire logic                 rst_n,
	input  wire logic [`INSN_W-1:0]   insnWord,
	input  wire logic                 insnValid,
	input  wire logic                 irqReq,
	input  wire logic [15:0]          memRdData,
	input  wire logic [15:0]          yRdData,
	input  wire logic [`INSN_W-1:0]   progRdData,
	output logic      [`PC_W-1:0]     progAddr,
	output logic      [`EXT_W-1:0]    dataAddr,
	output logic                      dataRd,
	output logic                      dataWr,
	output logic      [15:0]          dataWrData,
	output logic      [15:0]          yAddr,
	output logic                      yRd,
	output logic                      psvAccess,
	output logic                      insnDone,
	output logic                      irqTaken,
	output logic      [15:0]          operandA,
	output logic      [15:0]          operandB
);
	// ----------------------------------------
	// Instruction fields
	// ----------------------------------------
	// fixed 24-bit opcode: top nibble selects class and format
	wire logic [3:0]  opClass  = insnWord[23:20];
	wire logic        isDsp    = (opClass == 4'hc);
	wire logic        isMove   = (opClass == 4'h7) || (opClass == 4'h8);
	wire logic        isStore  = (opClass == 4'h8);
	wire logic        isDouble = (opClass == 4'h9);
	wire logic        isBranch = (opClass == 4'h0) && insnWord[19];
	wire logic        isRepeat = (opClass == 4'h1);
	wire logic        isDo     = (opClass == 4'h2);
	wire logic        isSfrWr  = (opClass == 4'h3);
	wire logic        isLitMov = (opClass == 4'h4);
	wire agu_pkg::ea_mode_t srcMode = agu_pkg::ea_mode_t'(insnWord[18:16]);
	wire logic [3:0]  ptrIdx   = insnWord[15:12];
	wire logic [3:0]  offIdx   = insnWord[11:8];
	wire logic [3:0]  dstIdx   = insnWord[7:4];
	wire logic [3:0]  yIdx     = insnWord[3:0];
	wire logic [15:0] literal  = {4'h0, insnWord[11:0]};

	// ----------------------------------------
	// Architectural state
	// ----------------------------------------
	logic [15:0]       wreg_q [`WREG_N];
	logic [`PC_W-1:0]  pc_q;
	logic [`PAGE_W-1:0] rdPage_q;
	logic [`PAGE_W-1:0] wrPage_q;
	logic [`PSV_W-1:0] psvPage_q;
	logic              psvEn_q;
	logic              xModEn_q;
	logic              yModEn_q;
	logic [15:0]       xModStart_q;
	logic [15:0]       xModEnd_q;
	logic              brevEn_q;
	logic [14:0]       brevMod_q;
	logic [13:0]       repCnt_q;
	logic [`PC_W-1:0]  loopStart_q;
	logic [`PC_W-1:0]  loopEnd_q;
	logic [13:0]       loopCnt_q;
	logic              loopAct_q;
	agu_pkg::seq_state_t state_q;
	agu_pkg::seq_state_t state_d;

	// ----------------------------------------
	// Address generators
	// ----------------------------------------
	logic [15:0] xEa;
	logic [15:0] xNewPtr;
	logic        xOver;
	logic        xUnder;
	logic        xWrap;
	logic [15:0] yEa;
	logic [15:0] yNewPtr;
	addr_calc #(.HAS_DSP(HAS_DSP)) xGen
	(
		.base     (wreg_q[ptrIdx]),
		.offset   (wreg_q[offIdx]),
		.mode     (srcMode),
		.modEn    (xModEn_q),
		.modStart (xModStart_q),
		.modEnd   (xModEnd_q),
		.brevEn   (brevEn_q),
		.brevMod  (brevMod_q),
		.ea       (xEa),
		.newPtr   (xNewPtr),
		.pageOver (xOver),
		.pageUnder(xUnder),
		.wrapMode (xWrap)
	);
	// Y generator for dual operand fetch
	addr_calc #(.HAS_DSP(HAS_DSP)) yGen
	(
		.base     (wreg_q[yIdx]),
		.offset   (16'h0000),
		.mode     (agu_pkg::AM_POST_INC),
		.modEn    (yModEn_q),
		.modStart (xModStart_q),
		.modEnd   (xModEnd_q),
		.brevEn   (1'b0),
		.brevMod  (15'h0000),
		.ea       (yEa),
		.newPtr   (yNewPtr),
		.pageOver (),
		.pageUnder(),
		.wrapMode ()
	);

	// ----------------------------------------
	// Extended address forming
	// ----------------------------------------
	// reduced variant rejects DSP class
	wire logic        dspOk     = HAS_DSP && isDsp;
	wire logic        memOp     = isMove || isDouble || dspOk;
	wire logic        directMd  = (srcMode == agu_pkg::AM_DIRECT);
	wire logic [15:0] baseEa    = directMd ? {insnWord[11:1], 5'h00} & 16'hfffe : xEa;
	// read page for reads, write page for writes
	wire logic [`PAGE_W-1:0] usePage = isStore ? wrPage_q : rdPage_q;
	wire logic        upperHalf = baseEa[`EA_TOP];
	wire logic        psvHit    = upperHalf && (psvEn_q || usePage >= `PAGE_PSV_MIN);
	wire logic [`PC_W-1:0] psvAddr = {psvPage_q, baseEa[14:0]};
	wire logic [`EXT_W-1:0] extAddr = upperHalf ?
		{usePage[8:0], baseEa[14:0]} : {8'h00, baseEa};
	wire logic        stepPage  = memOp && !xWrap && (xOver || xUnder);
	wire logic [`PAGE_W-1:0] pageStepped = xOver ? usePage + 10'h001 : usePage - 10'h001;
	wire logic [15:0] ptrFixed  = (xOver || xUnder) ? (xNewPtr | 16'h8000) : xNewPtr;

	// ----------------------------------------
	// Sequencing
	// ----------------------------------------
	// extra cycles for flow, double, window
	wire logic        multi     = isDouble || psvHit || isBranch;
	wire logic        repActive = (repCnt_q != 14'h0000);
	wire logic        takeIrq   = irqReq && (state_q != agu_pkg::ST_SECOND);
	wire logic        loopWrap  = loopAct_q && (pc_q == loopEnd_q) && (loopCnt_q != 14'h0000);

	always_comb
	begin
		state_d = state_q;
		case (state_q)
			agu_pkg::ST_IDLE:   if (insnValid && !takeIrq) state_d = agu_pkg::ST_ADDR;
			agu_pkg::ST_ADDR:   if (takeIrq) state_d = agu_pkg::ST_IDLE;
				else if (insnValid && multi) state_d = agu_pkg::ST_SECOND;
				else if (insnValid && isRepeat) state_d = agu_pkg::ST_REPEAT;
			agu_pkg::ST_SECOND: state_d = agu_pkg::ST_ADDR;
			agu_pkg::ST_REPEAT: if (takeIrq || repCnt_q[13:1] == 13'h0000) state_d = agu_pkg::ST_ADDR;
			default:            state_d = agu_pkg::ST_IDLE;
		endcase
	end

	wire logic execNow = insnValid && !takeIrq &&
		((state_q == agu_pkg::ST_ADDR && !multi) || state_q == agu_pkg::ST_SECOND ||
		state_q == agu_pkg::ST_REPEAT);

	// 23-bit program counter, word steps of two
	wire logic [`PC_W-1:0] pcNext = isBranch ? {insnWord[18:0], 4'h0} :
		loopWrap ? loopStart_q : pc_q + 23'h000002;

	always_ff @(posedge clock or negedge rst_n)
	begin
		if (!rst_n)
		begin
			state_q <= agu_pkg::ST_IDLE;
			pc_q    <= '0;
		end
		else
		begin
			state_q <= state_d;
			if (execNow && !(state_q == agu_pkg::ST_REPEAT && repActive))
				pc_q <= pcNext;
		end
	end

	// ----------------------------------------
	// Loop and repeat counters
	// ----------------------------------------
	always_ff @(posedge clock or negedge rst_n)
	begin
		if (!rst_n)
		begin
			repCnt_q    <= '0;
			loopAct_q   <= 1'b0;
			loopCnt_q   <= '0;
			loopStart_q <= '0;
			loopEnd_q   <= '0;
		end
		else
		begin
			if (execNow && isRepeat && !repActive)
				repCnt_q <= insnWord[13:0];
			else if (execNow && repActive)
				repCnt_q <= repCnt_q - 14'h0001;
			if (execNow && isDo)
			begin
				loopAct_q   <= 1'b1;
				loopCnt_q   <= insnWord[13:0];
				loopStart_q <= pc_q + 23'h000002;
				loopEnd_q   <= pc_q + {insnWord[19:14], 17'h00000};
			end
			else if (execNow && loopWrap)
				loopCnt_q <= loopCnt_q - 14'h0001;
			else if (execNow && loopAct_q && pc_q == loopEnd_q)
				loopAct_q <= 1'b0;
		end
	end

	// ----------------------------------------
	// Working registers and control registers
	// ----------------------------------------
	always_ff @(posedge clock or negedge rst_n)
	begin
		if (!rst_n)
		begin
			for (int i = 0; i < `WREG_N; i++)
				wreg_q[i] <= '0;
			rdPage_q    <= `PAGE_RST;
			wrPage_q    <= `PAGE_RST;
			psvPage_q   <= '0;
			psvEn_q     <= 1'b0;
			xModEn_q    <= 1'b0;
			yModEn_q    <= 1'b0;
			xModStart_q <= '0;
			xModEnd_q   <= `MOD_END_RST;
			brevEn_q    <= 1'b0;
			brevMod_q   <= '0;
		end
		else if (takeIrq && state_q != agu_pkg::ST_IDLE)
			wreg_q[`SP_IDX] <= wreg_q[`SP_IDX] + 16'h0004;
		else if (execNow)
		begin
			// any register as pointer, offset or data
			if (isLitMov)
				wreg_q[dstIdx] <= literal;
			if (isMove && !isStore)
				wreg_q[dstIdx] <= psvHit ? progRdData[15:0] : memRdData;
			if (memOp && srcMode != agu_pkg::AM_OFFSET && !directMd)
				wreg_q[ptrIdx] <= ptrFixed;
			if (dspOk)
				wreg_q[yIdx] <= yNewPtr;
			if (stepPage && isStore)
				wrPage_q <= pageStepped;
			else if (stepPage)
				rdPage_q <= pageStepped;
			if (isSfrWr)
			begin
				case (insnWord[19:16])
					4'h0: rdPage_q <= wreg_q[offIdx][`PAGE_W-1:0];
					4'h1: wrPage_q <= wreg_q[offIdx][`PAGE_W-1:0];
					4'h2: {psvEn_q, psvPage_q} <= wreg_q[offIdx][8:0];
					4'h3: {xModEn_q, yModEn_q} <= wreg_q[offIdx][15:14];
					4'h4: xModStart_q <= wreg_q[offIdx] & 16'hfffe;
					4'h5: xModEnd_q <= wreg_q[offIdx] | 16'h0001;
					4'h6: {brevEn_q, brevMod_q} <= wreg_q[offIdx];
					default: ;
				endcase
			end
		end
	end

	// ----------------------------------------
	// Memory side outputs
	// ----------------------------------------
	always_ff @(posedge clock or negedge rst_n)
	begin
		if (!rst_n)
		begin
			dataAddr   <= '0;
			dataRd     <= 1'b0;
			dataWr     <= 1'b0;
			dataWrData <= '0;
			yAddr      <= '0;
			yRd        <= 1'b0;
			psvAccess  <= 1'b0;
			operandA   <= '0;
			operandB   <= '0;
		end
		else
		begin
			dataAddr   <= extAddr;
			dataRd     <= execNow && memOp && !isStore;
			dataWr     <= execNow && isStore;
			dataWrData <= wreg_q[dstIdx];
			yAddr      <= yEa;
			yRd        <= execNow && dspOk;
			psvAccess  <= execNow && psvHit && !isStore;
			operandA   <= memRdData;
			operandB   <= yRdData;
		end
	end

	assign progAddr = psvHit && state_q == agu_pkg::ST_ADDR ? psvAddr : pc_q;
	assign insnDone = execNow;
	assign irqTaken = takeIrq && state_q != agu_pkg::ST_IDLE;

	// ----------------------------------------
	// Checks
	// ----------------------------------------
	default clocking cb @(posedge clock); endclocking
	default disable iff (!rst_n);

	even_addr_a: assert property (dataRd |-> dataAddr[0] == 1'b0)
		else $error("data word address is odd");
	pc_step_a: assert property (insnDone && !isBranch && !loopWrap && state_q != agu_pkg::ST_REPEAT
		|=> pc_q == $past(pc_q) + 23'h000002)
		else $error("pc did not step by two");
	store_page_a: assert property (dataWr && $past(upperHalf) |-> dataAddr[23:15] == $past(wrPage_q[8:0]))
		else $error("store did not use write page");
	multi_cycle_a: assert property (state_q == agu_pkg::ST_ADDR && multi && insnValid && !takeIrq
		|=> state_q == agu_pkg::ST_SECOND ##1 state_q == agu_pkg::ST_ADDR)
		else $error("long instruction sequence wrong");
	irq_repeat_a: assert property (state_q == agu_pkg::ST_REPEAT && irqReq |=> state_q != agu_pkg::ST_REPEAT)
		else $error("repeat not suspended by interrupt");
	sp_push_a: assert property (irqTaken |=> wreg_q[`SP_IDX] == $past(wreg_q[`SP_IDX]) + 16'h0004)
		else $error("stack pointer not advanced");
	no_dsp_a: assert property (!HAS_DSP |-> !yRd)
		else $error("reduced core issued dual read");
	page_step_a: assert property (execNow && stepPage && !isStore && xOver
		|=> rdPage_q == $past(rdPage_q) + 10'h001)
		else $error("page not incremented on overflow");
	wrap_keep_a: assert property (execNow && xWrap && !isSfrWr |=> $stable(rdPage_q))
		else $error("page changed on wrapping mode");

	cov_branch_c: cover property (insnDone && isBranch);
	cov_repeat_c: cover property (state_q == agu_pkg::ST_REPEAT ##1 irqTaken);
	cov_psv_c: cover property (psvAccess);
	cov_dual_c: cover property (yRd && dataRd);
endmodule : cpu_data_space_addressing

// ---- test/mem_model.sv ----
// Program and data memory models computing read data from the address outputs
`timescale 1ns/100ps
module mem_model
(
	input  wire logic [23:0] dataAddr,
	input  wire logic [15:0] yAddr,
	input  wire logic [22:0] progAddr,
	output logic      [15:0] memRdData,
	output logic      [15:0] yRdData,
	output logic      [23:0] progRdData
);
	assign memRdData  = dataAddr[15:0] ^ 16'h5a3c ^ {dataAddr[23:16], 8'h00};
	assign yRdData    = yAddr ^ 16'hc3a5;
	assign progRdData = {1'b0, progAddr} ^ 24'h96e1d2;
endmodule : mem_model

// ---- test/cpu_data_space_addressing_tb.sv ----
// Self-checking bench for the core address generation block
`timescale 1ns/100ps
module cpu_data_space_addressing_tb;
	logic        clock;
	logic        rst_n;
	logic [23:0] insnWord;
	logic        insnValid;
	logic        irqReq;
	logic [15:0] memRdData;
	logic [15:0] yRdData;
	logic [23:0] progRdData;
	logic [22:0] progAddr;
	logic [23:0] dataAddr;
	logic        dataRd;
	logic        dataWr;
	logic [15:0] dataWrData;
	logic [15:0] yAddr;
	logic        yRd;
	logic        psvAccess;
	logic        insnDone;
	logic        irqTaken;
	logic [15:0] operandA;
	logic [15:0] operandB;
	logic        redRd;
	logic        redYRd;
	logic [22:0] pcExp;
	int          err_count;
	int          check_count;
	int          seed;
	int          i;

	cpu_data_space_addressing #(.HAS_DSP(1'b1)) i_dut
	(
		.clock(clock), .rst_n(rst_n), .insnWord(insnWord), .insnValid(insnValid),
		.irqReq(irqReq), .memRdData(memRdData), .yRdData(yRdData),
		.progRdData(progRdData), .progAddr(progAddr), .dataAddr(dataAddr),
		.dataRd(dataRd), .dataWr(dataWr), .dataWrData(dataWrData), .yAddr(yAddr),
		.yRd(yRd), .psvAccess(psvAccess), .insnDone(insnDone), .irqTaken(irqTaken),
		.operandA(operandA), .operandB(operandB)
	);

	mem_model i_mem
	(
		.dataAddr(dataAddr), .yAddr(yAddr), .progAddr(progAddr),
		.memRdData(memRdData), .yRdData(yRdData), .progRdData(progRdData)
	);

	// reduced core beside the full one
	cpu_data_space_addressing #(.HAS_DSP(1'b0)) i_red
	(
		.clock(clock), .rst_n(rst_n), .insnWord(insnWord), .insnValid(insnValid),
		.irqReq(irqReq), .memRdData(memRdData), .yRdData(yRdData),
		.progRdData(progRdData), .progAddr(), .dataAddr(), .dataRd(redRd), .dataWr(),
		.dataWrData(), .yAddr(), .yRd(redYRd), .psvAccess(), .insnDone(), .irqTaken(),
		.operandA(), .operandB()
	);

	always #50 clock = ~clock;

	// Expected data word at an extended byte address
	function automatic logic [15:0] memExp(input logic [23:0] a);
		memExp = a[15:0] ^ 16'h5a3c ^ {a[23:16], 8'h00};
	endfunction : memExp

	task automatic summarize();
		$display("checks %0d mismatches %0d", check_count, err_count);
		if (err_count == 0 && check_count > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask : summarize

	task automatic check(input logic [23:0] seen, input logic [23:0] exp, input string msg);
		check_count++;
		if (seen !== exp)
		begin
			err_count++;
			$display("wrong value at %0t: %s seen %h expected %h", $time, msg, seen, exp);
		end
	endtask : check

	// One instruction: wait cycles before it executes, then the pulses that follow it
	task automatic runInsn(input logic [23:0] w, input int lat, input bit chkPulse);
		int          n;
		logic        rdExp;
		logic [23:0] addr;
		logic [15:0] yA;
		rdExp = (w[23:20] == 4'h7) || (w[23:20] == 4'hc) || (w[23:20] == 4'h9);
		@(posedge clock);
		#1;
		insnValid = 1'b1;
		insnWord  = w;
		n = 0;
		#1;
		while (insnDone !== 1'b1 && n < 8)
		begin
			@(posedge clock);
			#2;
			n++;
		end
		check(n, lat, "cycles to execute");
		@(posedge clock);
		#1;
		insnValid = 1'b0;
		insnWord  = 24'($random(seed));
		pcExp     = pcExp + 23'h000002;
		check(progAddr, pcExp, "program counter");
		// reduced core never reads for the signal class
		check({redYRd, redRd}, {1'b0, rdExp && w[23:20] != 4'hc}, "reduced reads");
		if (chkPulse)
		begin
			check(dataRd, rdExp, "read pulse");
			check(dataWr, w[23:20] == 4'h8, "write pulse");
			check(yRd, w[23:20] == 4'hc, "y read pulse");
			check(psvAccess, 1'b0, "window access");
		end
		addr = dataAddr;
		yA   = yAddr;
		@(posedge clock);
		#1;
		check(dataRd | dataWr | yRd, 1'b0, "pulse length");
		if (chkPulse && rdExp)
			check(operandA, memExp(addr), "loaded operand");
		if (chkPulse && w[23:20] == 4'hc)
			check(operandB, yA ^ 16'hc3a5, "second operand");
	endtask : runInsn

	initial
	begin
		#2000000;
		err_count++;
		summarize();
	end

	initial
	begin
		logic [3:0]  ops [5];
		logic [23:0] w;
		ops       = '{4'h7, 4'h8, 4'hc, 4'h4, 4'h9};
		clock     = 1'b0;
		rst_n     = 1'b0;
		insnWord  = 24'h000000;
		insnValid = 1'b0;
		irqReq    = 1'b0;
		err_count   = 0;
		check_count = 0;
		seed        = 32'hd422;
		pcExp       = '0;
		repeat (2) @(posedge clock);
		#1;
		rst_n = 1'b1;
		check(progAddr, 23'h000000, "reset pc");
		check({dataRd, dataWr, yRd, psvAccess, irqTaken}, 5'h00, "reset pulses");
		check(dataAddr, 24'h000000, "reset address");
		// Five classes with corner fields, then random traffic over the first four
		for (i = 0; i < 5; i++)
			runInsn({ops[i], 1'b0, agu_pkg::AM_PLAIN, 16'hffff}, (i == 0 || i == 4) ? 1 : 0, 1'b1);
		for (i = 0; i < 150; i++)
		begin
			w = 24'($random(seed));
			w[23:20] = ops[$unsigned($random(seed)) % 4];
			w[19] = 1'b0;
			if (w[18:16] == 3'h7)
				w[18:16] = 3'h5;
			runInsn(w, 0, 1'b1);
		end
		@(posedge clock);
		#1;
		insnValid = 1'b1;
		insnWord  = {4'h1, 6'h00, 14'h0003};
		@(posedge clock);
		#1;
		irqReq = 1'b1;
		pcExp  = pcExp + 23'h000002;
		#1;
		check(irqTaken, 1'b1, "repeat suspended");
		@(posedge clock);
		#1;
		irqReq    = 1'b0;
		insnValid = 1'b0;
		check(progAddr, pcExp, "repeat program counter");
		@(posedge clock);
		#1;
		insnValid = 1'b1;
		insnWord  = {4'h7, 1'b0, agu_pkg::AM_POST_INC, 16'h1234};
		irqReq    = 1'b1;
		#1;
		i = 0;
		while (irqTaken !== 1'b1 && i < 8)
		begin
			@(posedge clock);
			#1;
			i++;
		end
		check(irqTaken, 1'b1, "interrupt taken");
		check(insnDone, 1'b0, "no execution on interrupt");
		@(posedge clock);
		#1;
		irqReq    = 1'b0;
		insnValid = 1'b0;
		check(dataRd, 1'b0, "aborted read");
		runInsn({4'h7, 1'b0, agu_pkg::AM_PLAIN, 16'h4321}, 1, 1'b1);
		summarize();
	end
endmodule : cpu_data_space_addressing_tb
